// file: hdl/rbc_pkg.sv
package rbc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_INSTR     = 8'h00;
    localparam logic [7:0] OFS_IRQPIN    = 8'h04;
    localparam logic [7:0] OFS_WAKEEN    = 8'h08;
    localparam logic [7:0] OFS_STATUS    = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h14;
    localparam logic [7:0] OFS_PTR_VALID = 8'h18;
    // instruction strobe bits
    localparam int unsigned INS_ARM     = 0;
    localparam int unsigned INS_ENTER   = 1;
    localparam int unsigned INS_IRQ_DIS = 2;
    localparam int unsigned INS_CER_SEL = 3;
    localparam int unsigned INS_RC_SEL  = 4;
    localparam int unsigned INS_WDIS    = 5;
    localparam int unsigned INS_WD_RST  = 6;
    localparam int unsigned INS_OTHER   = 7;
    // irq pin control fields
    localparam int unsigned IPC_EDGE       = 2;
    localparam int unsigned IPC_BACKUP_SEL = 3;
    localparam logic [3:0]  IPC_RST        = 4'h8;
    // status bits
    localparam int unsigned STS_RUN     = 0;
    localparam int unsigned STS_BACKUP  = 1;
    localparam int unsigned STS_OSC_LO  = 2;
    localparam int unsigned STS_OSC_HI  = 3;
    localparam int unsigned STS_WDT     = 4;
    localparam int unsigned STS_EXTCLK  = 5;
    localparam int unsigned STS_IRQ_EN  = 6;
    localparam int unsigned STS_ARMED   = 7;
    // event bits
    localparam int unsigned EV_W       = 4;
    localparam int unsigned EV_ENTER   = 0;
    localparam int unsigned EV_WAKE    = 1;
    localparam int unsigned EV_REFUSED = 2;
    localparam int unsigned EV_STAB    = 3;
    // oscillator selection codes
    localparam logic [1:0] OSC_NONE = 2'h0;
    localparam logic [1:0] OSC_CER  = 2'h1;
    localparam logic [1:0] OSC_RC   = 2'h2;
    // pointer register valid bits: z, x, y, d, e
    localparam int unsigned PTR_W   = 5;
    localparam logic [4:0]  PTR_RST = 5'h06;
    localparam logic [4:0]  PTR_NONE = 5'h00;
    localparam int unsigned STAB_EDGES = 16;
    typedef enum logic [2:0] {
        ST_STAB   = 3'b001,
        ST_RUN    = 3'b010,
        ST_BACKUP = 3'b100
    } rbc_state_e;
endpackage

// file: hdl/rbc_ctrl.sv
// Overview of operation
// - z, d, e pointers undefined after reset
// - enter backup only right after arm
// - enabled key pin low wakes from backup
// - z, x, y, d, e undefined after wakeup
// - watchdog active after every wakeup
// - irq pin bit3 clear: backup mode, int off
// - no backup with external clock source
// - first oscillator select wins, others stop
// - stabilize wait counted on on-chip oscillator
`timescale 1ns/10ps
`default_nettype none
module rbc_ctrl
    import rbc_pkg::*;
#(
    parameter int unsigned KEY_W      = 8,
    parameter int unsigned STAB_COUNT = STAB_EDGES
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [7:0]        paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic [KEY_W-1:0]  key_n_i,
    input  wire logic              int_pin_i,
    input  wire logic              onchip_osc_i,
    input  wire logic              ext_clk_strap_i,
    output logic                   core_run_o,
    output logic                   ram_hold_o,
    output logic                   osc_cer_en_o,
    output logic                   osc_rc_en_o,
    output logic                   onchip_osc_en_o,
    output logic                   int_in_o,
    output logic                   wdt_active_o,
    output logic                   irq_o
);
    // refused at elaboration; stab_cnt is eight bits wide
    if (KEY_W < 1 || KEY_W > 24) begin : g_bad_key_w
        $error("KEY_W out of range");
    end
    if (STAB_COUNT < 1 || STAB_COUNT > 255) begin : g_bad_stab
        $error("STAB_COUNT out of range");
    end

    typedef struct packed {
        rbc_state_e       state;
        logic [KEY_W-1:0] key_s1;
        logic [KEY_W-1:0] key_s2;
        logic [1:0]       int_s;
        logic [2:0]       osc_s;
        logic [1:0]       ext_s;
        logic             ext_clk;
        logic             strap_done;
        logic [7:0]       stab_cnt;
        logic             armed;
        logic             wdis_seen;
        logic             irq_en;
        logic [1:0]       osc_sel;
        logic [3:0]       ipc;
        logic [KEY_W-1:0] wake_en;
        logic [EV_W-1:0]  ev_stat;
        logic [EV_W-1:0]  ev_mask;
        logic [PTR_W-1:0] ptr_valid;
        logic             wdt;
        logic [31:0]      rdata;
        logic             ready;
        logic             slverr;
        logic             irq;
    } rbc_s;

    localparam rbc_s RST_VAL = '{
        state:     ST_STAB,
        key_s1:    '1,
        key_s2:    '1,
        int_s:     '0,
        osc_s:     '0,
        ext_s:     '0,
        ext_clk:   1'b0,
        strap_done: 1'b0,
        stab_cnt:  '0,
        armed:     1'b0,
        wdis_seen: 1'b0,
        irq_en:    1'b0,
        osc_sel:   OSC_NONE,
        ipc:       IPC_RST,
        wake_en:   '0,
        ev_stat:   '0,
        ev_mask:   '0,
        ptr_valid: PTR_RST,
        wdt:       1'b1,
        rdata:     '0,
        ready:     1'b0,
        slverr:    1'b0,
        irq:       1'b0
    };

    rbc_s s_reg;
    rbc_s s_next;

    logic            wr_done;
    logic            mapped;
    logic [7:0]      ins;
    logic            key_wake;
    logic            osc_rise;
    logic [EV_W-1:0] ev_set;
    logic [31:0]     status;

    always_comb begin
        s_next   = s_reg;
        ev_set   = '0;
        ins      = '0;
        // synchronisers; the second stage feeds logic, the oscillator's third stage only the edge detect
        s_next.key_s1 = key_n_i;
        s_next.key_s2 = s_reg.key_s1;
        s_next.int_s  = {s_reg.int_s[0], int_pin_i};
        s_next.osc_s  = {s_reg.osc_s[1:0], onchip_osc_i};
        s_next.ext_s  = {s_reg.ext_s[0], ext_clk_strap_i};
        osc_rise = s_reg.osc_s[1] & ~s_reg.osc_s[2];
        // strap caught once, at the first synced oscillator edge:
        // by then its synchroniser holds the pin, not the reset zeros
        if (!s_reg.strap_done && osc_rise) begin
            s_next.strap_done = 1'b1;
            s_next.ext_clk    = s_reg.ext_s[1];
        end
        key_wake = |(~s_reg.key_s2 & s_reg.wake_en);

        mapped = (paddr_i == OFS_INSTR) || (paddr_i == OFS_IRQPIN) ||
                 (paddr_i == OFS_WAKEEN) || (paddr_i == OFS_STATUS) ||
                 (paddr_i == OFS_IRQ_STAT) || (paddr_i == OFS_IRQ_MASK) ||
                 (paddr_i == OFS_PTR_VALID);
        wr_done = psel_i & penable_i & s_reg.ready & pwrite_i & mapped;
        // instructions only execute while the core runs
        if (wr_done && paddr_i == OFS_INSTR && s_reg.state == ST_RUN) begin
            ins = pwdata_i[7:0];
        end

        unique case (s_reg.state)
            ST_STAB: begin
                // timed on the on-chip oscillator, not the main one
                if (osc_rise) begin
                    if (s_reg.stab_cnt == 8'(STAB_COUNT - 1)) begin
                        s_next.stab_cnt = '0;
                        s_next.state    = ST_RUN;
                        ev_set[EV_STAB] = 1'b1;
                    end else begin
                        s_next.stab_cnt = s_reg.stab_cnt + 8'h01;
                    end
                end
            end
            ST_RUN: begin
                if (ins[INS_ENTER]) begin
                    // entry needs arm just before, backup mode, no ext clock
                    if (s_reg.armed && !s_reg.ipc[IPC_BACKUP_SEL]
                        && !s_reg.ext_clk) begin
                        s_next.state     = ST_BACKUP;
                        ev_set[EV_ENTER] = 1'b1;
                    end else begin
                        ev_set[EV_REFUSED] = 1'b1;
                    end
                end
                // arm survives idle cycles, but only until the very next instruction
                if (|ins) begin
                    s_next.armed = ins[INS_ARM] & ~(|ins[7:1]);
                end
                if (|ins) begin
                    s_next.wdis_seen = ins[INS_WDIS] & ~ins[INS_WD_RST];
                end
                if (s_reg.wdis_seen && ins[INS_WD_RST]) begin
                    s_next.wdt = 1'b0;
                end
                if (ins[INS_IRQ_DIS]) begin
                    s_next.irq_en = 1'b0;
                end
                // one shot; the earlier instruction wins
                if (s_reg.osc_sel == OSC_NONE) begin
                    if (ins[INS_CER_SEL]) begin
                        s_next.osc_sel = OSC_CER;
                    end else if (ins[INS_RC_SEL]) begin
                        s_next.osc_sel = OSC_RC;
                    end
                end
            end
            ST_BACKUP: begin
                s_next.armed = 1'b0;
                if (key_wake) begin
                    s_next.state     = ST_STAB;
                    s_next.stab_cnt  = '0;
                    s_next.wdt       = 1'b1;
                    s_next.wdis_seen = 1'b0;
                    s_next.ptr_valid = PTR_NONE;
                    ev_set[EV_WAKE]  = 1'b1;
                end
            end
            default: begin
                s_next.state = ST_STAB;
            end
        endcase

        status = '0;
        status[STS_RUN]    = s_reg.state == ST_RUN;
        status[STS_BACKUP] = s_reg.state == ST_BACKUP;
        status[STS_OSC_LO] = s_reg.osc_sel[0];
        status[STS_OSC_HI] = s_reg.osc_sel[1];
        status[STS_WDT]    = s_reg.wdt;
        status[STS_EXTCLK] = s_reg.ext_clk;
        status[STS_IRQ_EN] = s_reg.irq_en;
        status[STS_ARMED]  = s_reg.armed;

        if (wr_done) begin
            unique case (paddr_i)
                OFS_IRQPIN:    s_next.ipc = pwdata_i[3:0];
                OFS_WAKEEN:    s_next.wake_en = pwdata_i[KEY_W-1:0];
                OFS_IRQ_MASK:  s_next.ev_mask = pwdata_i[EV_W-1:0];
                OFS_PTR_VALID: s_next.ptr_valid = s_reg.ptr_valid | pwdata_i[PTR_W-1:0];
                default: begin
                end
            endcase
        end
        // write-one-to-clear; a new event in the same cycle wins
        if (wr_done && paddr_i == OFS_IRQ_STAT) begin
            s_next.ev_stat = (s_reg.ev_stat & ~pwdata_i[EV_W-1:0]) | ev_set;
        end else begin
            s_next.ev_stat = s_reg.ev_stat | ev_set;
        end
        // new mask too, so a mask write shows on irq together with the status
        s_next.irq = |(s_next.ev_stat & s_next.ev_mask);

        // no wait state; read data is captured in the setup cycle so it comes from a flop
        s_next.ready  = psel_i & ~penable_i;
        s_next.slverr = psel_i & ~penable_i & ~mapped;
        s_next.rdata  = '0;
        if (psel_i && !penable_i) begin
            unique case (paddr_i)
                OFS_IRQPIN:    s_next.rdata[3:0] = s_reg.ipc;
                OFS_WAKEEN:    s_next.rdata[KEY_W-1:0] = s_reg.wake_en;
                OFS_STATUS:    s_next.rdata = status;
                OFS_IRQ_STAT:  s_next.rdata[EV_W-1:0] = s_reg.ev_stat;
                OFS_IRQ_MASK:  s_next.rdata[EV_W-1:0] = s_reg.ev_mask;
                OFS_PTR_VALID: s_next.rdata[PTR_W-1:0] = s_reg.ptr_valid;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= RST_VAL;
        end else begin
            s_reg <= s_next;
        end
    end

    // pin-facing outputs registered so they come straight from flops
    logic core_run_reg;
    logic ram_hold_reg;
    logic cer_reg;
    logic rc_reg;
    logic onchip_reg;
    logic int_in_reg;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            core_run_reg <= 1'b0;
            ram_hold_reg <= 1'b0;
            cer_reg      <= 1'b0;
            rc_reg       <= 1'b0;
            onchip_reg   <= 1'b1;
            int_in_reg   <= 1'b0;
        end else begin
            core_run_reg <= s_next.state == ST_RUN;
            ram_hold_reg <= s_next.state == ST_BACKUP;
            // every oscillator stops in backup
            cer_reg      <= s_next.osc_sel == OSC_CER && s_next.state != ST_BACKUP;
            rc_reg       <= s_next.osc_sel == OSC_RC && s_next.state != ST_BACKUP;
            onchip_reg   <= s_next.osc_sel == OSC_NONE && s_next.state != ST_BACKUP;
            int_in_reg   <= s_reg.int_s[1] & s_next.ipc[IPC_BACKUP_SEL];
        end
    end

    assign prdata_o        = s_reg.rdata;
    assign pready_o        = s_reg.ready;
    assign pslverr_o       = s_reg.slverr;
    assign wdt_active_o    = s_reg.wdt;
    assign irq_o           = s_reg.irq;
    assign core_run_o      = core_run_reg;
    assign ram_hold_o      = ram_hold_reg;
    assign osc_cer_en_o    = cer_reg;
    assign osc_rc_en_o     = rc_reg;
    assign onchip_osc_en_o = onchip_reg;
    assign int_in_o        = int_in_reg;
endmodule // rbc_ctrl
`default_nettype wire

// file: testbench/rbc_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module rbc_ctrl_monitor
    import rbc_pkg::*;
#(
    parameter int unsigned KEY_W      = 8,
    parameter int unsigned STAB_COUNT = 16
) (
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic        onchip_osc_i,
    input wire logic        ext_clk_strap_i,
    input wire logic        core_run_o,
    input wire logic        ram_hold_o,
    input wire logic        osc_cer_en_o,
    input wire logic        osc_rc_en_o,
    input wire logic        onchip_osc_en_o,
    input wire logic        int_in_o,
    input wire logic        wdt_active_o
);
    logic       enter_wr;
    logic [2:0] osc_q;
    logic [7:0] osc_edges;
    assign enter_wr = psel_i && penable_i && pwrite_i && pready_o
                      && paddr_i == OFS_INSTR && pwdata_i[INS_ENTER];
    // two-flop sync and edge pick, so an edge caught just before wakeup
    // is counted here exactly when the core counts it
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            osc_q     <= 3'h0;
            osc_edges <= 8'h00;
        end else begin
            osc_q <= {osc_q[1:0], onchip_osc_i};
            if (ram_hold_o) begin
                osc_edges <= 8'h00;
            end else if (osc_q[1] && !osc_q[2] && osc_edges != 8'hFF) begin
                osc_edges <= osc_edges + 8'h01;
            end
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_hold_core_halt: assert property (
        ram_hold_o |-> !core_run_o && !onchip_osc_en_o && !osc_cer_en_o && !osc_rc_en_o)
        else $error("core or oscillator alive in backup");
    a_enter_after_write: assert property (
        $rose(ram_hold_o) |-> $past(enter_wr, 1) || $past(enter_wr, 2))
        else $error("backup entered without enter write");
    a_no_ext_backup: assert property (ext_clk_strap_i |-> !ram_hold_o)
        else $error("backup with external clock");
    a_osc_exclusive: assert property (!(osc_cer_en_o && osc_rc_en_o))
        else $error("both oscillators running");
    a_osc_onchip_stop: assert property (
        (osc_cer_en_o || osc_rc_en_o) |-> !onchip_osc_en_o)
        else $error("on-chip oscillator still on");
    a_wake_wdt_on: assert property ($fell(ram_hold_o) |-> ##[0:1] wdt_active_o)
        else $error("watchdog off after wakeup");
    a_stab_edges: assert property ($rose(core_run_o) |-> osc_edges >= STAB_COUNT)
        else $error("core ran before stabilize wait");
    a_int_gated: assert property (ram_hold_o |-> !int_in_o)
        else $error("int input live in backup mode");
    c_enter: cover property ($rose(ram_hold_o));
    c_wake: cover property ($fell(ram_hold_o));
    c_cer: cover property ($rose(osc_cer_en_o));
endmodule // rbc_ctrl_monitor
bind rbc_ctrl rbc_ctrl_monitor #(.KEY_W(KEY_W), .STAB_COUNT(STAB_COUNT)) u_mon (
    .clk_sys_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
    .onchip_osc_i, .ext_clk_strap_i, .core_run_o, .ram_hold_o, .osc_cer_en_o,
    .osc_rc_en_o, .onchip_osc_en_o, .int_in_o, .wdt_active_o);
`default_nettype wire

// file: testbench/rbc_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module rbc_far_model #(
    parameter int unsigned KEY_W = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_req_i,
    input  wire logic [KEY_W-1:0] press_i,
    output logic                  rst_o = 1'b1,
    output logic                  osc_o = 1'b0,
    output logic      [KEY_W-1:0] key_n_o
);
    int cnt = 0;
    // free running, unrelated to the system clock
    always #37 osc_o = ~osc_o;
    // pull-ups hold idle keys high before entry
    assign key_n_o = ~press_i;
    // pulse stretched to well over one machine cycle
    always @(posedge clk_i) begin
        if (rst_req_i)
            cnt <= 0;
        else if (cnt < 10)
            cnt <= cnt + 1;
        rst_o <= rst_req_i || cnt < 10;
    end
endmodule // rbc_far_model
`default_nettype wire

// file: testbench/rbc_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
module rbc_ctrl_bench
    import rbc_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst_req = 1'b0;
    logic        ext_strap = 1'b0;
    logic        int_pin = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [7:0]  press = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdata;
    logic [7:0]  key_n;
    logic        rst, pready, pslverr, last_err, osc, core_run, ram_hold;
    logic        cer_en, rc_en, onchip_en, int_in, wdt, irq;
    int          err_total = 0;
    int          tests_run = 0;
    always #10 clk_sys = ~clk_sys;
    rbc_far_model #(.KEY_W(8)) u_far (.clk_i(clk_sys), .rst_req_i(rst_req), .press_i(press),
        .rst_o(rst), .osc_o(osc), .key_n_o(key_n));
    rbc_ctrl #(.KEY_W(8), .STAB_COUNT(2)) u_dut (.clk_sys_i(clk_sys), .rst_i(rst),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .key_n_i(key_n), .int_pin_i(int_pin), .onchip_osc_i(osc), .ext_clk_strap_i(ext_strap),
        .core_run_o(core_run), .ram_hold_o(ram_hold), .osc_cer_en_o(cer_en),
        .osc_rc_en_o(rc_en), .onchip_osc_en_o(onchip_en), .int_in_o(int_in),
        .wdt_active_o(wdt), .irq_o(irq));
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_total++;
            final_report();
        end else begin
            @(posedge clk_sys);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(rdata & m, exp);
    endtask
    task automatic ins(input int b);
        apb(1'b1, OFS_INSTR, 32'h1 << b);
    endtask
    // sel 0 watches core_run, sel 1 watches ram_hold
    task automatic wait_for(input int sel, input logic v);
        int n;
        for (n = 0; n < 400; n++) begin
            if ((sel == 0 ? core_run : ram_hold) === v)
                return;
            @(posedge clk_sys);
        end
        err_total++;
        final_report();
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        rd(OFS_IRQPIN, 32'h8, 32'hF);
        rd(OFS_PTR_VALID, 32'h06, 32'h1F);
        rd(8'h1C, 32'h0, 32'hFFFFFFFF);
        chk({31'h0, last_err}, 32'h1);
        chk({31'h0, int_in}, 32'h1);
        int_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk({31'h0, int_in}, 32'h0);
        int_pin <= 1'b1;
        wait_for(0, 1'b1);
        rd(OFS_IRQ_STAT, 32'h8, 32'hF);
        apb(1'b1, OFS_IRQ_MASK, 32'h8);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, OFS_IRQ_STAT, 32'h8);
        chk({31'h0, irq}, 32'h0);
        ins(INS_CER_SEL);
        ins(INS_RC_SEL);
        chk({29'h0, cer_en, rc_en, onchip_en}, 32'h4);
        rd(OFS_STATUS, 32'h4, 32'hC);
        ins(INS_WDIS);
        ins(INS_WD_RST);
        chk({31'h0, wdt}, 32'h0);
        apb(1'b1, OFS_IRQPIN, 32'h0);
        chk({31'h0, int_in}, 32'h0);
        apb(1'b1, OFS_WAKEEN, 32'h1);
        ins(INS_IRQ_DIS);
        ins(INS_ENTER);
        @(posedge clk_sys);
        chk({31'h0, ram_hold}, 32'h0);
        rd(OFS_IRQ_STAT, 32'h4, 32'h4);
        chk({31'h0, irq}, 32'h0);
        ins(INS_ARM);
        ins(INS_OTHER);
        ins(INS_ENTER);
        @(posedge clk_sys);
        chk({31'h0, ram_hold}, 32'h0);
        ins(INS_ARM);
        ins(INS_ENTER);
        wait_for(1, 1'b1);
        repeat (20) @(posedge clk_sys);
        chk({30'h0, ram_hold, core_run}, 32'h2);
        press <= 8'h01;
        wait_for(1, 1'b0);
        chk({31'h0, wdt}, 32'h1);
        press <= 8'h00;
        wait_for(0, 1'b1);
        rd(OFS_PTR_VALID, 32'h0, 32'h1F);
        rd(OFS_IRQ_STAT, 32'h3, 32'h3);
        ext_strap <= 1'b1;
        rst_req <= 1'b1;
        @(posedge clk_sys);
        rst_req <= 1'b0;
        repeat (12) @(posedge clk_sys);
        wait_for(0, 1'b1);
        ins(INS_RC_SEL);
        ins(INS_CER_SEL);
        chk({29'h0, cer_en, rc_en, onchip_en}, 32'h2);
        apb(1'b1, OFS_IRQPIN, 32'h0);
        ins(INS_IRQ_DIS);
        ins(INS_ARM);
        ins(INS_ENTER);
        @(posedge clk_sys);
        chk({31'h0, ram_hold}, 32'h0);
        rd(OFS_IRQ_STAT, 32'h4, 32'h4);
        final_report();
    end
endmodule // rbc_ctrl_bench
`default_nettype wire
